// *** ebp_pkg.sv ***
// Functional notes
// - In standby, input pins float and output pins hold their entry level.
// - With the standby float bit set, held output pins float during standby.
// - Wait-input pull-up is switched on when its enable is 1, off at 0 and in standby.
// - Multiplexed I/O space raises the address hold strobe while address is out.
// - DRAM accesses assert the row strobe while the row address is driven.
// - 8-bit DRAM uses only the lower column strobe; upper stays high.
// - 16-bit two-column DRAM asserts the upper column strobe for upper or word.
// - 16-bit two-column DRAM asserts the lower column strobe for lower or word; two-write-strobe DRAM for every lane.
// - DRAM parity selected: on writes parity pins carry active lanes, idle lanes float.
// - External memory drives low only the accessed area's chip select.
// - Area 2 parity selected: on writes parity pins carry parity of active lanes.
// - Multiplexed I/O holds chip select six low; read strobe low on reads.
// - On-chip accesses keep strobes high, data floating, address still driven.
package ebp_pkg;
    typedef enum logic [2:0] {
        SPACE_ROM = 3'h0,
        SPACE_RAM = 3'h1,
        SPACE_MUX = 3'h2,
        SPACE_DRAM = 3'h3,
        SPACE_EXT = 3'h4
    } ebp_space_e;

    // Gray sequence along the usual path idle, address, data, recovery
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ADDR = 2'h1,
        ST_DATA = 2'h3,
        ST_END = 2'h2
    } ebp_state_e;

    localparam logic [1:0] PCHK_NONE = 2'h0;
    localparam logic [1:0] PCHK_DRAM = 2'h1;
    localparam logic [1:0] PCHK_AREA2 = 2'h2;
    localparam logic [2:0] PARITY_AREA = 3'h2;
    localparam int MUX_CS_IDX = 6;
    localparam int DRAM_CS_IDX = 1;
    localparam int ROW_SHIFT = 11;
    localparam int NUM_CS = 8;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam logic [1:0] LANE_LOWER = 2'h1;
    localparam logic [1:0] LANE_UPPER = 2'h2;
    localparam logic [1:0] LANE_WORD = 2'h3;
    localparam logic ODD_PARITY = 1'b1;
    localparam logic [7:0] CS_ALL_HIGH = 8'hFF;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
endpackage : ebp_pkg

// *** ebp_parity.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebp_parity (
    input wire logic [15:0] data_in,
    output logic [1:0] parity_out
);
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_lane
            assign parity_out[g] = (^data_in[g*8 +: 8]) ^ ebp_pkg::ODD_PARITY;
        end
    endgenerate
endmodule : ebp_parity
`default_nettype wire

// *** ebp_lane_strobe.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebp_lane_strobe (
    input wire logic wide_in,
    input wire logic [1:0] lane_in,
    input wire logic write_in,
    input wire logic byte_strobe_mode_in,
    input wire logic two_we_in,
    input wire logic dram_in,
    input wire logic addr0_in,
    output logic upper_active_out,
    output logic lower_active_out,
    output logic upper_write_strobe_n_out,
    output logic lower_write_strobe_n_out,
    output logic a0_pin_out
);
    always_comb
    begin
        upper_active_out = wide_in & lane_in[1];
        lower_active_out = ~wide_in | lane_in[0];
        upper_write_strobe_n_out = 1'b1;
        lower_write_strobe_n_out = 1'b1;
        a0_pin_out = addr0_in;
        if (!wide_in)
        begin
            // Upper strobe has no meaning for 8-bit space; left idle high
            lower_write_strobe_n_out = ~write_in;
        end
        else if (dram_in && !two_we_in)
        begin
            lower_write_strobe_n_out = ~write_in;
        end
        else if (dram_in)
        begin
            upper_write_strobe_n_out = ~(write_in & lane_in[1]);
            lower_write_strobe_n_out = ~(write_in & lane_in[0]);
        end
        else if (byte_strobe_mode_in)
        begin
            lower_write_strobe_n_out = ~write_in;
            upper_write_strobe_n_out = ~lane_in[0];
            a0_pin_out = ~lane_in[1];
        end
        else
        begin
            upper_write_strobe_n_out = ~(write_in & lane_in[1]);
            lower_write_strobe_n_out = ~(write_in & lane_in[0]);
            a0_pin_out = lane_in == ebp_pkg::LANE_LOWER;
        end
    end
endmodule : ebp_lane_strobe
`default_nettype wire

// *** ebp_bus_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebp_bus_pins (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire logic [2:0] req_space_in,
    input wire logic req_wide_in,
    input wire logic [1:0] req_lane_in,
    input wire logic req_write_in,
    input wire logic [2:0] req_area_in,
    input wire logic [21:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic dram_two_we_in,
    input wire logic byte_strobe_mode_in,
    input wire logic [1:0] parity_check_select_in,
    input wire logic standby_in,
    input wire logic standby_output_float_in,
    input wire logic wait_input_pullup_enable_in,
    input wire logic wait_n_in,
    input wire logic [15:0] shared_addr_data_pins_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [15:0] rd_data_out,
    output logic [7:0] chip_select_n_out,
    output logic row_strobe_n_out,
    output logic upper_column_strobe_n_out,
    output logic lower_column_strobe_n_out,
    output logic address_hold_strobe_out,
    output logic read_strobe_n_out,
    output logic upper_write_strobe_n_out,
    output logic lower_write_strobe_n_out,
    output logic [21:0] address_pins_out,
    output logic ctrl_oe_out,
    output logic [15:0] shared_addr_data_pins_out,
    output logic [1:0] shared_addr_data_pins_oe_out,
    output logic upper_parity_pin_out,
    output logic upper_parity_pin_oe_out,
    output logic lower_parity_pin_out,
    output logic lower_parity_pin_oe_out,
    output logic wait_pullup_out
);
    typedef struct packed {
        ebp_pkg::ebp_state_e st;
        ebp_pkg::ebp_space_e space;
        logic wide;
        logic [1:0] lane;
        logic write;
        logic [2:0] area;
        logic [21:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic done;
        logic [7:0] cs_n;
        logic ras_n;
        logic cu_n;
        logic cl_n;
        logic hold;
        logic rd_n;
        logic wu_n;
        logic wl_n;
        logic [21:0] apins;
        logic [15:0] ad;
        logic [1:0] ad_oe;
        logic [1:0] par;
        logic [1:0] par_oe;
        logic ctrl_oe;
        logic pull;
        logic dphase;
    } ebp_regs_s;

    ebp_regs_s s;
    ebp_regs_s next_s;
    logic up_act;
    logic lo_act;
    logic lane_wu_n;
    logic lane_wl_n;
    logic lane_a0;
    logic [1:0] wpar;
    logic is_dram;

    assign is_dram = s.space == ebp_pkg::SPACE_DRAM;

    ebp_lane_strobe u_lane (
        .wide_in(s.wide),
        .lane_in(s.lane),
        .write_in(s.write),
        .byte_strobe_mode_in(byte_strobe_mode_in),
        .two_we_in(dram_two_we_in),
        .dram_in(is_dram),
        .addr0_in(s.addr[0]),
        .upper_active_out(up_act),
        .lower_active_out(lo_act),
        .upper_write_strobe_n_out(lane_wu_n),
        .lower_write_strobe_n_out(lane_wl_n),
        .a0_pin_out(lane_a0)
    );

    ebp_parity u_parity (
        .data_in(s.wdata),
        .parity_out(wpar)
    );

    always_comb
    begin
        logic need_wait;
        logic par_on;
        logic two_cas16;
        need_wait = 1'b0;
        par_on = 1'b0;
        two_cas16 = 1'b0;
        next_s = s;
        next_s.done = 1'b0;
        if (standby_in)
        begin
            // Outputs keep their level; the float bit releases them
            next_s.ctrl_oe = ~standby_output_float_in;
            next_s.ad_oe = 2'h0;
            next_s.par_oe = 2'h0;
            next_s.pull = 1'b0;
        end
        else
        begin
            next_s.ctrl_oe = 1'b1;
            next_s.pull = wait_input_pullup_enable_in;
            need_wait = (s.space == ebp_pkg::SPACE_MUX) || is_dram ||
                (s.space == ebp_pkg::SPACE_EXT);
            case (s.st)
                ebp_pkg::ST_IDLE:
                begin
                    if (req_valid_in)
                    begin
                        next_s.st = ebp_pkg::ST_ADDR;
                        next_s.space = ebp_pkg::ebp_space_e'(req_space_in);
                        next_s.wide = req_wide_in;
                        next_s.lane = req_wide_in ? req_lane_in
                            : ebp_pkg::LANE_LOWER;
                        next_s.write = req_write_in;
                        next_s.area = req_area_in;
                        next_s.addr = req_addr_in;
                        next_s.wdata = req_wdata_in;
                    end
                end
                ebp_pkg::ST_ADDR:
                begin
                    next_s.st = ebp_pkg::ST_DATA;
                end
                ebp_pkg::ST_DATA:
                begin
                    // Data pins lag the state, so sample and honour wait
                    // only once the strobes are really out
                    if (s.dphase && !(need_wait && !wait_n_in))
                    begin
                        next_s.st = ebp_pkg::ST_END;
                        next_s.done = 1'b1;
                        if (!s.write)
                        begin
                            next_s.rdata = shared_addr_data_pins_in;
                        end
                    end
                end
                ebp_pkg::ST_END:
                begin
                    next_s.st = ebp_pkg::ST_IDLE;
                end
                default:
                begin
                    next_s.st = ebp_pkg::ST_IDLE;
                end
            endcase

            // Pin levels follow the registered state one cycle later
            next_s.cs_n = ebp_pkg::CS_ALL_HIGH;
            next_s.ras_n = 1'b1;
            next_s.cu_n = 1'b1;
            next_s.cl_n = 1'b1;
            next_s.hold = 1'b0;
            next_s.rd_n = 1'b1;
            next_s.wu_n = 1'b1;
            next_s.wl_n = 1'b1;
            next_s.apins = s.addr;
            next_s.ad = s.wdata;
            next_s.ad_oe = 2'h0;
            next_s.par = wpar;
            next_s.par_oe = 2'h0;
            next_s.dphase = s.st == ebp_pkg::ST_DATA;
            if (s.st == ebp_pkg::ST_ADDR || s.st == ebp_pkg::ST_DATA)
            begin
                case (s.space)
                    ebp_pkg::SPACE_MUX:
                    begin
                        next_s.cs_n[ebp_pkg::MUX_CS_IDX] = 1'b0;
                        next_s.apins[0] = lane_a0;
                        if (s.st == ebp_pkg::ST_ADDR)
                        begin
                            next_s.ad = s.addr[15:0];
                            next_s.ad_oe = 2'h3;
                            next_s.hold = 1'b1;
                        end
                        else
                        begin
                            next_s.rd_n = s.write;
                            next_s.wu_n = lane_wu_n;
                            next_s.wl_n = lane_wl_n;
                            next_s.ad_oe = {up_act & s.write,
                                lo_act & s.write};
                        end
                    end
                    ebp_pkg::SPACE_DRAM:
                    begin
                        two_cas16 = s.wide && !dram_two_we_in;
                        par_on = parity_check_select_in == ebp_pkg::PCHK_DRAM;
                        next_s.ras_n = 1'b0;
                        next_s.cs_n[ebp_pkg::DRAM_CS_IDX] = two_cas16;
                        if (s.st == ebp_pkg::ST_ADDR)
                        begin
                            next_s.apins = s.addr >> ebp_pkg::ROW_SHIFT;
                        end
                        else
                        begin
                            // Upper strobe only in two-column 16-bit mode
                            next_s.cu_n = ~(two_cas16 & up_act);
                            next_s.cl_n = ~(lo_act |
                                (s.wide & dram_two_we_in));
                            if (two_cas16)
                            begin
                                // Chip select one doubles as upper column
                                next_s.cs_n[ebp_pkg::DRAM_CS_IDX] =
                                    ~up_act;
                            end
                            next_s.rd_n = s.write;
                            next_s.wu_n = lane_wu_n;
                            next_s.wl_n = lane_wl_n;
                            next_s.ad_oe = {up_act & s.write,
                                lo_act & s.write};
                            next_s.par_oe = {up_act & s.write & par_on,
                                lo_act & s.write & par_on};
                        end
                    end
                    ebp_pkg::SPACE_EXT:
                    begin
                        par_on = (parity_check_select_in ==
                            ebp_pkg::PCHK_AREA2) &&
                            (s.area == ebp_pkg::PARITY_AREA);
                        next_s.cs_n[s.area] = 1'b0;
                        next_s.apins[0] = lane_a0;
                        if (s.st == ebp_pkg::ST_DATA)
                        begin
                            next_s.rd_n = s.write;
                            next_s.wu_n = lane_wu_n;
                            next_s.wl_n = lane_wl_n;
                            next_s.ad_oe = {up_act & s.write,
                                lo_act & s.write};
                            next_s.par_oe = {up_act & s.write & par_on,
                                lo_act & s.write & par_on};
                        end
                    end
                    default:
                    begin
                        // On-chip space: only the address pins move
                        next_s.cs_n = ebp_pkg::CS_ALL_HIGH;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s <= '{st: ebp_pkg::ST_IDLE, space: ebp_pkg::SPACE_ROM,
                wide: 1'b0, lane: ebp_pkg::LANE_LOWER, write: 1'b0,
                area: 3'h0, addr: 22'h000000, wdata: ebp_pkg::DATA_ZERO,
                rdata: ebp_pkg::DATA_ZERO, done: 1'b0,
                cs_n: ebp_pkg::CS_ALL_HIGH, ras_n: 1'b1, cu_n: 1'b1,
                cl_n: 1'b1, hold: 1'b0, rd_n: 1'b1, wu_n: 1'b1, wl_n: 1'b1,
                apins: 22'h000000, ad: ebp_pkg::DATA_ZERO, ad_oe: 2'h0,
                par: 2'h0, par_oe: 2'h0, ctrl_oe: 1'b1, pull: 1'b0,
                dphase: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign req_ready_out = (s.st == ebp_pkg::ST_IDLE) && !standby_in;
    assign done_out = s.done;
    assign rd_data_out = s.rdata;
    assign chip_select_n_out = s.cs_n;
    assign row_strobe_n_out = s.ras_n;
    assign upper_column_strobe_n_out = s.cu_n;
    assign lower_column_strobe_n_out = s.cl_n;
    assign address_hold_strobe_out = s.hold;
    assign read_strobe_n_out = s.rd_n;
    assign upper_write_strobe_n_out = s.wu_n;
    assign lower_write_strobe_n_out = s.wl_n;
    assign address_pins_out = s.apins;
    assign ctrl_oe_out = s.ctrl_oe;
    assign shared_addr_data_pins_out = s.ad;
    assign shared_addr_data_pins_oe_out = s.ad_oe;
    assign upper_parity_pin_out = s.par[1];
    assign upper_parity_pin_oe_out = s.par_oe[1];
    assign lower_parity_pin_out = s.par[0];
    assign lower_parity_pin_oe_out = s.par_oe[0];
    assign wait_pullup_out = s.pull;
endmodule : ebp_bus_pins
`default_nettype wire

// *** ebp_bus_pins_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebp_bus_pins_props (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic standby_in,
    input wire logic standby_output_float_in,
    input wire logic wait_input_pullup_enable_in,
    input wire logic [7:0] chip_select_n_out,
    input wire logic row_strobe_n_out,
    input wire logic upper_column_strobe_n_out,
    input wire logic lower_column_strobe_n_out,
    input wire logic address_hold_strobe_out,
    input wire logic ctrl_oe_out,
    input wire logic [15:0] shared_addr_data_pins_out,
    input wire logic [1:0] shared_addr_data_pins_oe_out,
    input wire logic upper_parity_pin_out,
    input wire logic upper_parity_pin_oe_out,
    input wire logic lower_parity_pin_out,
    input wire logic lower_parity_pin_oe_out,
    input wire logic wait_pullup_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    one_cs_low_a: assert property (
        $countones(~chip_select_n_out) <= 1) else $error("two selects low");
    // Standby forces the lanes off, so the check skips it
    mux_hold_a: assert property (
        address_hold_strobe_out && !standby_in && !$past(standby_in) |->
        !chip_select_n_out[6] && shared_addr_data_pins_oe_out == 2'h3 &&
        row_strobe_n_out && upper_column_strobe_n_out &&
        lower_column_strobe_n_out) else $error("hold strobe misplaced");
    col_row_a: assert property (
        !(upper_column_strobe_n_out && lower_column_strobe_n_out) |->
        !row_strobe_n_out) else $error("column strobe without row");
    par_up_a: assert property (
        upper_parity_pin_oe_out |-> shared_addr_data_pins_oe_out[1] &&
        upper_parity_pin_out == ~^shared_addr_data_pins_out[15:8])
        else $error("upper parity wrong");
    par_lo_a: assert property (
        lower_parity_pin_oe_out |-> shared_addr_data_pins_oe_out[0] &&
        lower_parity_pin_out == ~^shared_addr_data_pins_out[7:0])
        else $error("lower parity wrong");
    pullup_a: assert property (
        $past(rst_n_in) && !$past(standby_in) |->
        wait_pullup_out == $past(wait_input_pullup_enable_in))
        else $error("pull-up does not follow enable");
    float_a: assert property (
        $past(standby_in) && $past(standby_output_float_in) |->
        !ctrl_oe_out && shared_addr_data_pins_oe_out == 2'h0 &&
        !upper_parity_pin_oe_out && !lower_parity_pin_oe_out)
        else $error("pins not floated in standby");
    sby_hold_a: assert property (
        $past(standby_in, 2) && $past(standby_in) &&
        !$past(standby_output_float_in) |-> ctrl_oe_out &&
        $stable(chip_select_n_out) && $stable(row_strobe_n_out))
        else $error("pin levels moved in standby");
    cover property (address_hold_strobe_out);
    cover property (!upper_column_strobe_n_out && !lower_column_strobe_n_out);
    cover property (lower_parity_pin_oe_out);
    cover property ($past(standby_in) && !ctrl_oe_out);
endmodule : ebp_bus_pins_props
bind ebp_bus_pins ebp_bus_pins_props ebp_bus_pins_props_inst (
    .clk_sys_in, .rst_n_in, .standby_in, .standby_output_float_in,
    .wait_input_pullup_enable_in, .chip_select_n_out, .row_strobe_n_out,
    .upper_column_strobe_n_out, .lower_column_strobe_n_out,
    .address_hold_strobe_out, .ctrl_oe_out, .shared_addr_data_pins_out,
    .shared_addr_data_pins_oe_out, .upper_parity_pin_out,
    .upper_parity_pin_oe_out, .lower_parity_pin_out,
    .lower_parity_pin_oe_out, .wait_pullup_out);
`default_nettype wire

// *** ebp_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebp_mem_model #(
    parameter logic [15:0] RD_PAT = 16'h5AC3
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    output logic [15:0] data_out,
    output logic wait_n_out
);
    logic [15:0] last;
    logic [1:0] cnt;
    logic act;
    // Only read and main write strobe are watched; the upper one can lie
    assign act = !rd_n_in || !wr_n_in;
    // Released bus toggles so that stale data never looks right
    assign data_out = rd_n_in ? last : RD_PAT;
    assign wait_n_out = !(slow_in && act && cnt < 2'h2);
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt <= 2'h0;
            last <= 16'hFFFF;
        end
        else
        begin
            cnt <= act ? cnt + {1'b0, cnt != 2'h3} : 2'h0;
            last <= ~last;
        end
    end
endmodule : ebp_mem_model
`default_nettype wire

// *** ebp_bus_pins_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebp_bus_pins_tb;
    localparam logic [15:0] PAT = 16'h5AC3;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
    logic req_wide_in = 1'b0, req_write_in = 1'b0, dram_two_we_in = 1'b0;
    logic byte_strobe_mode_in = 1'b0, standby_in = 1'b0, slow = 1'b0;
    logic standby_output_float_in = 1'b0, wait_input_pullup_enable_in = 1'b0;
    logic [2:0] req_space_in = 3'h0, req_area_in = 3'h0;
    logic [1:0] req_lane_in = 2'h1, parity_check_select_in = 2'h0;
    logic [21:0] req_addr_in = 22'h2A5C3E;
    logic [15:0] req_wdata_in = 16'hC396;
    logic wait_n_in, req_ready_out, done_out, row_strobe_n_out, ctrl_oe_out;
    logic upper_column_strobe_n_out, lower_column_strobe_n_out;
    logic address_hold_strobe_out, read_strobe_n_out, wait_pullup_out;
    logic upper_write_strobe_n_out, lower_write_strobe_n_out;
    logic upper_parity_pin_out, upper_parity_pin_oe_out;
    logic lower_parity_pin_out, lower_parity_pin_oe_out;
    logic [15:0] rd_data_out, shared_addr_data_pins_out, mem_d, oe_m;
    logic [15:0] shared_addr_data_pins_in;
    logic [1:0] shared_addr_data_pins_oe_out;
    logic [7:0] chip_select_n_out;
    logic [21:0] address_pins_out;
    logic [18:0] seen;
    int err_count = 0;
    int n_tests = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    assign oe_m = {{8{shared_addr_data_pins_oe_out[1]}},
        {8{shared_addr_data_pins_oe_out[0]}}};
    assign shared_addr_data_pins_in = shared_addr_data_pins_out & oe_m |
        mem_d & ~oe_m;
    ebp_bus_pins ebp_bus_pins_inst (.clk_sys_in, .rst_n_in, .req_valid_in,
        .req_space_in, .req_wide_in, .req_lane_in, .req_write_in,
        .req_area_in, .req_addr_in, .req_wdata_in, .dram_two_we_in,
        .byte_strobe_mode_in, .parity_check_select_in, .standby_in,
        .standby_output_float_in, .wait_input_pullup_enable_in, .wait_n_in,
        .shared_addr_data_pins_in, .req_ready_out, .done_out, .rd_data_out,
        .chip_select_n_out, .row_strobe_n_out, .upper_column_strobe_n_out,
        .lower_column_strobe_n_out, .address_hold_strobe_out,
        .read_strobe_n_out, .upper_write_strobe_n_out,
        .lower_write_strobe_n_out, .address_pins_out, .ctrl_oe_out,
        .shared_addr_data_pins_out, .shared_addr_data_pins_oe_out,
        .upper_parity_pin_out, .upper_parity_pin_oe_out,
        .lower_parity_pin_out, .lower_parity_pin_oe_out, .wait_pullup_out);
    ebp_mem_model #(.RD_PAT(PAT)) ebp_mem_model_inst (.clk_in(clk_sys_in),
        .rst_n_in(rst_n_in), .slow_in(slow), .rd_n_in(read_strobe_n_out),
        .wr_n_in(lower_write_strobe_n_out), .data_out(mem_d),
        .wait_n_out(wait_n_in));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Pins seen active during a transfer: {parity oe, data oe, cs,
    // row, upper col, lower col, hold, read, upper wr, lower wr}
    function automatic logic [18:0] pins(input logic [2:0] sp,
        input logic w, input logic [1:0] ln, input logic wr,
        input logic [2:0] ar);
        logic [7:0] cs;
        logic [1:0] la, par;
        logic dr, mx, we2, bm, wh, wl;
        la = w ? ln : 2'h1;
        dr = sp == ebp_pkg::SPACE_DRAM;
        mx = sp == ebp_pkg::SPACE_MUX;
        we2 = w && dram_two_we_in;
        bm = w && byte_strobe_mode_in && !dr;
        cs = 8'h00;
        par = 2'h0;
        if (sp < ebp_pkg::SPACE_MUX)
            return 19'h00000;
        if (mx)
            cs[6] = 1'b1;
        else if (dr)
            cs[1] = !w || we2 || la[1];
        else
            cs[ar] = 1'b1;
        wh = bm ? la[0] : wr && la[1] && (!dr || we2);
        wl = bm ? wr : wr && (dr && !we2 || la[0]);
        if (wr && (dr ? parity_check_select_in == ebp_pkg::PCHK_DRAM :
            parity_check_select_in == ebp_pkg::PCHK_AREA2 && ar == 3'h2 && !mx))
            par = la;
        return {par, wr ? la : 2'h0, cs, dr, dr && w && !we2 && la[1],
            dr && (!w || we2 || la[0]), mx, !wr, wh, wl};
    endfunction : pins
    task automatic xfer(input logic [2:0] sp, input logic w,
        input logic [1:0] ln, input logic wr, input logic [2:0] ar);
        int i, n;
        logic [15:0] m, dq;
        logic [21:0] ra;
        logic a0;
        @(posedge clk_sys_in);
        #1;
        {req_space_in, req_wide_in, req_lane_in} = {sp, w, ln};
        {req_write_in, req_area_in, req_valid_in} = {wr, ar, 1'b1};
        seen = 19'h00000;
        n = 0;
        @(posedge clk_sys_in);
        #1;
        req_valid_in = 1'b0;
        // Pins lag the state, so two samples follow the done pulse
        for (i = 0; i < 40 && n != 1; i++)
        begin
            @(negedge clk_sys_in);
            seen |= {upper_parity_pin_oe_out, lower_parity_pin_oe_out,
                address_hold_strobe_out ? 2'h0 : shared_addr_data_pins_oe_out,
                ~chip_select_n_out, ~row_strobe_n_out,
                ~upper_column_strobe_n_out, ~lower_column_strobe_n_out,
                address_hold_strobe_out, ~read_strobe_n_out,
                ~upper_write_strobe_n_out, ~lower_write_strobe_n_out};
            if (!row_strobe_n_out && upper_column_strobe_n_out &&
                lower_column_strobe_n_out)
                ra = address_pins_out;
            if (!(read_strobe_n_out && upper_write_strobe_n_out &&
                lower_write_strobe_n_out))
                a0 = address_pins_out[0];
            if (shared_addr_data_pins_oe_out != 2'h0 &&
                !address_hold_strobe_out)
                dq = shared_addr_data_pins_out;
            n = done_out ? 3 : (n > 0 ? n - 1 : 0);
        end
        if (n != 1)
        begin
            err_count++;
            wrap_up();
        end
        if (!w && sp != ebp_pkg::SPACE_DRAM)
            seen[1] = 1'b0;
        chk(seen, pins(sp, w, ln, wr, ar));
        m = {{8{ln[1]}}, {8{ln[0]}}};
        if (w && sp > ebp_pkg::SPACE_RAM)
            chk((wr ? dq : rd_data_out) & m,
                (wr ? req_wdata_in : PAT) & m);
        if (sp == ebp_pkg::SPACE_DRAM)
            chk(ra, req_addr_in >> ebp_pkg::ROW_SHIFT);
        else if (sp > ebp_pkg::SPACE_RAM)
            chk(a0, w ? !ln[1] : req_addr_in[0]);
    endtask : xfer
    initial
    begin : main
        int c, k;
        logic [2:0] sp, a;
        repeat (8) @(posedge clk_sys_in);
        #1;
        rst_n_in = 1'b1;
        xfer(ebp_pkg::SPACE_ROM, 1'b0, 2'h1, 1'b0, 3'h0);
        xfer(ebp_pkg::SPACE_RAM, 1'b1, 2'h3, 1'b1, 3'h0);
        for (c = 0; c < 6; c++)
        begin
            @(posedge clk_sys_in);
            #1;
            {dram_two_we_in, slow, byte_strobe_mode_in} = {c[0], c[0], c[1]};
            parity_check_select_in = c[2:1];
            for (k = 0; k < 24; k++)
            begin
                sp = 3'(2 + k / 8);
                a = c[2] ? 3'h2 : k[2:0];
                xfer(sp, k[2:1] != 0, k[2:1], k[0], a);
            end
        end
        for (k = 0; k < 4; k++)
        begin
            @(posedge clk_sys_in);
            #1;
            {standby_output_float_in, wait_input_pullup_enable_in} = k[1:0];
            standby_in = 1'b1;
            repeat (3) @(posedge clk_sys_in);
            #1;
            chk({req_ready_out, ctrl_oe_out}, {1'b0, !k[1]});
            chk(shared_addr_data_pins_oe_out, 2'h0);
            standby_in = 1'b0;
            repeat (2) @(posedge clk_sys_in);
            #1;
            chk(wait_pullup_out, k[0]);
        end
        wrap_up();
    end
endmodule : ebp_bus_pins_tb
`default_nettype wire
